// File: rtl/measurement_query_sequencer.v
/*
 Measurement query sequencer: expands read and measure queries into abort, configure,
 initiate and fetch steps, tracks trigger-model state, buffer lockout and an error queue.
 Assumes an APB master on pclk; a measurement engine outside hands back readings on a
 one-cycle strobe; the channel switch and function settings are driven from here.
*/
// The implementer's own choices: the APB slave port and the address map.
`include "query_seq_map.vh"

// How it works
// (R1) Read runs abort, initiate, fetch in order
// (R2) Abort without continuous mode enters idle
// (R3) Abort with continuous mode restarts trigger model
// (R4) Initiate from idle leaves idle state
// (R5) Initiate under continuous mode ignored, error -213
// (R6) Read under continuous mode posts error -213
// (R7) Reset clears continuous mode, one-shot mode
// (R8) Sample count above one stores readings
// (R9) Stored buffer locks out initiate, error -225
// (R10) Reset and preset never clear buffer
// (R11) Controller should clear buffer first
// (R12) Digits derived from resolution and range
// (R13) Fewer than three-and-half digits clamp up
// (R14) Over seven-and-half digits: discard, error -221
// (R15) Named channel closes before measuring
// (R16) Measure selects function, applies range, resolution
// (R17) No function named: use present function
// (R18) Measure runs abort, configure, read in order
// (R19) Configure applies arguments, then one-shot mode
// (R20) Data format ASCII, single, double; ASCII default
// (R21) Six selectable reading string elements
// (R22) Byte order normal on reset, swapped preset
// (R23) Fetch returns latest reading, no trigger
// (R24) Errors queued in arrival order
module measurement_query_sequencer #(
   parameter ERRQ_DEPTH = 8,
   parameter ERRQ_AW = 3,
   parameter BUF_DEPTH = 16,
   parameter BUF_AW = 4
)(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire meas_done,
   input wire [31:0] meas_data,
   output wire trig_start,
   output wire trig_idle,
   output wire func_defaults,
   output wire [3:0] func_sel,
   output wire [3:0] range_sel,
   output wire [3:0] digits,
   output wire chan_close,
   output wire [7:0] chan_num
);

// ------------------------------------------------------------
// Sequencer states
// ------------------------------------------------------------
localparam S_IDLE = 3'h0;
localparam S_ABORT = 3'h1;
localparam S_CONFIG = 3'h2;
localparam S_INIT = 3'h3;
localparam S_WAIT = 3'h4;
localparam S_FETCH = 3'h5;

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg is_meas_ff;
reg cont_ff;
reg [15:0] samp_cnt_ff;
reg [15:0] taken_ff;
reg armed_ff;
reg locked_ff;
reg [3:0] func_ff;
reg [3:0] range_ff;
reg [3:0] digits_ff;
reg [7:0] chan_ff;
reg chan_close_ff;
reg [31:0] args_ff;
reg [31:0] latest_ff;
reg fresh_ff;
reg [1:0] fmt_data_ff;
reg [5:0] fmt_elem_ff;
reg fmt_swap_ff;
reg [31:0] buf_mem [0:BUF_DEPTH-1];
reg [BUF_AW-1:0] buf_wp_ff;
reg [BUF_AW:0] buf_cnt_ff;
reg [15:0] errq_mem [0:ERRQ_DEPTH-1];
reg [ERRQ_AW-1:0] errq_wp_ff;
reg [ERRQ_AW-1:0] errq_rp_ff;
reg [ERRQ_AW:0] errq_cnt_ff;
reg err_push;
reg [15:0] err_code;

// ------------------------------------------------------------
// APB decode
// ------------------------------------------------------------
wire wr_en = psel & penable & pwrite;
wire rd_en = psel & penable & ~pwrite;
wire hit = (paddr == `OFS_CMD) | (paddr == `OFS_ARGS) | (paddr == `OFS_CTRL) |
   (paddr == `OFS_STATUS) | (paddr == `OFS_ERRQ) | (paddr == `OFS_FMT) |
   (paddr == `OFS_READING) | (paddr == `OFS_BUFCLR);
assign pready = 1'b1;
assign pslverr = psel & penable & ~hit;
wire cmd_wr = wr_en & (paddr == `OFS_CMD);
wire [3:0] cmd = pwdata[3:0];
wire busy = (state_ff != S_IDLE);
wire errq_pop = rd_en & (paddr == `OFS_ERRQ) & (errq_cnt_ff != {(ERRQ_AW+1){1'b0}});

// ------------------------------------------------------------
// Digit computation from resolution and range
// ------------------------------------------------------------
// Range code is the decade exponent of full scale, resolution code the decade count
// below one; the digit count is their sum, with the half digit implied.
wire [3:0] arg_res = pwdata[`ARG_RES_LSB +: 4];
wire [3:0] arg_rng = pwdata[`ARG_RANGE_LSB +: 4];
wire [4:0] raw_dig = {1'b0, arg_res} + {1'b0, arg_rng}; // R12
wire dig_over = raw_dig > {1'b0, `DIG_MAX}; // R14
wire [3:0] dig_use = (raw_dig < {1'b0, `DIG_MIN}) ? `DIG_MIN : raw_dig[3:0]; // R13
wire multi = (samp_cnt_ff > 16'h0001);

// ------------------------------------------------------------
// Command acceptance and error detection
// ------------------------------------------------------------
reg start_read;
reg start_meas;
always @*
begin
   err_push = 1'b0;
   err_code = 16'h0000;
   start_read = 1'b0;
   start_meas = 1'b0;
   if (cmd_wr && !busy)
   begin
      case (cmd)
         `CMD_READ:
         begin
            if (cont_ff)
            begin
               err_push = 1'b1; // R6
               err_code = `ERR_INIT_IGN;
            end
            else if (locked_ff && multi)
            begin
               err_push = 1'b1; // R9
               err_code = `ERR_MEMORY;
            end
            else
               start_read = 1'b1;
         end
         `CMD_MEAS:
         begin
            if (dig_over)
            begin
               err_push = 1'b1; // R14
               err_code = `ERR_SETTINGS;
            end
            else
               start_meas = 1'b1;
         end
         `CMD_INIT:
         begin
            if (cont_ff)
            begin
               err_push = 1'b1; // R5
               err_code = `ERR_INIT_IGN;
            end
            else if (locked_ff)
            begin
               err_push = 1'b1; // R9
               err_code = `ERR_MEMORY;
            end
         end
         default:
         begin
            err_push = 1'b0;
         end
      endcase
   end
end

// ------------------------------------------------------------
// Sequence state machine
// ------------------------------------------------------------
always @*
begin
   nxt_state = state_ff;
   case (state_ff)
      S_IDLE:
         if (start_read || start_meas)
            nxt_state = S_ABORT;
      S_ABORT:
         nxt_state = is_meas_ff ? S_CONFIG : S_INIT; // R1 R18
      S_CONFIG:
         nxt_state = S_ABORT; // R18
      S_INIT:
         nxt_state = S_WAIT;
      S_WAIT:
         if (meas_done && (taken_ff + 16'h0001 >= samp_cnt_ff))
            nxt_state = S_FETCH;
      S_FETCH:
         nxt_state = S_IDLE; // R1
      default:
         nxt_state = S_IDLE;
   endcase
end

assign trig_start = (state_ff == S_INIT) | (cmd_wr & !busy & (cmd == `CMD_INIT) &
   !cont_ff & !locked_ff); // R4
assign trig_idle = !armed_ff;
assign func_defaults = (state_ff == S_CONFIG); // R16 R17
assign func_sel = func_ff;
assign range_sel = range_ff;
assign digits = digits_ff;
assign chan_close = chan_close_ff;
assign chan_num = chan_ff;

wire ctrl_wr = wr_en & (paddr == `OFS_CTRL);
wire is_rst = cmd_wr & !busy & (cmd == `CMD_RST);
wire is_pre = cmd_wr & !busy & (cmd == `CMD_PRESET);

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      state_ff <= S_IDLE;
      is_meas_ff <= 1'b0;
      cont_ff <= 1'b0;
      samp_cnt_ff <= 16'h0001;
      taken_ff <= 16'h0000;
      armed_ff <= 1'b0;
      func_ff <= 4'h0;
      range_ff <= 4'h0;
      digits_ff <= 4'h6;
      chan_ff <= 8'h00;
      chan_close_ff <= 1'b0;
      args_ff <= 32'h00000000;
      latest_ff <= 32'h00000000;
      fresh_ff <= 1'b0;
      fmt_data_ff <= `FMT_ASCII;
      fmt_elem_ff <= `ELEM_RESET;
      fmt_swap_ff <= 1'b0;
   end
   else
   begin
      state_ff <= nxt_state;
      if (start_read || start_meas)
      begin
         is_meas_ff <= start_meas;
         args_ff <= pwdata;
      end
      if (start_meas)
         digits_ff <= dig_use; // R12 R13
      if (state_ff == S_ABORT)
      begin
         armed_ff <= cont_ff; // R2 R3
         taken_ff <= 16'h0000;
      end
      if (state_ff == S_CONFIG)
      begin
         if (args_ff[`ARG_FUNCV_BIT])
            func_ff <= args_ff[`ARG_FUNC_LSB +: 4]; // R16 R17
         range_ff <= args_ff[`ARG_RANGE_LSB +: 4]; // R19
         chan_close_ff <= args_ff[`ARG_CHV_BIT]; // R15
         chan_ff <= args_ff[`ARG_CH_LSB +: 8];
         cont_ff <= 1'b0; // R19
         is_meas_ff <= 1'b0;
      end
      if (trig_start)
         armed_ff <= 1'b1; // R4
      if (state_ff == S_WAIT && meas_done)
         taken_ff <= taken_ff + 16'h0001;
      if (meas_done)
      begin
         latest_ff <= meas_data; // R23
         fresh_ff <= 1'b1;
      end
      if (state_ff == S_FETCH)
      begin
         armed_ff <= cont_ff;
         chan_close_ff <= 1'b0;
      end
      if (cmd_wr && !busy && cmd == `CMD_ABORT)
         armed_ff <= cont_ff; // R2 R3
      if (wr_en && paddr == `OFS_ARGS)
         samp_cnt_ff <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      if (ctrl_wr && !busy)
      begin
         cont_ff <= pwdata[0];
         armed_ff <= pwdata[0] | armed_ff;
      end
      if (wr_en && paddr == `OFS_FMT)
      begin
         fmt_data_ff <= (pwdata[1:0] == 2'h3) ? `FMT_ASCII : pwdata[1:0]; // R20
         fmt_elem_ff <= pwdata[`FMT_ELEM_LSB +: 6]; // R21
         fmt_swap_ff <= pwdata[`FMT_SWAP_BIT];
      end
      if (rd_en && paddr == `OFS_READING)
         fresh_ff <= meas_done; // R23
      if (is_rst || is_pre)
      begin
         cont_ff <= 1'b0; // R7
         armed_ff <= 1'b0;
         fmt_data_ff <= `FMT_ASCII;
         fmt_elem_ff <= `ELEM_RESET;
         fmt_swap_ff <= is_pre; // R22
      end
   end
end

// ------------------------------------------------------------
// Reading buffer (storage kept across reset and preset commands)
// ------------------------------------------------------------
wire buf_clr = wr_en & (paddr == `OFS_BUFCLR);
wire buf_wr = meas_done & (state_ff == S_WAIT) & multi; // R8
wire buf_full = (buf_cnt_ff == BUF_DEPTH[BUF_AW:0]);
always @(posedge pclk)
begin
   if (buf_wr && !buf_full)
      buf_mem[buf_wp_ff] <= meas_data;
end

// The hardware reset pin and a write to the buffer clear register empty the buffer; the reset and preset commands do not
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      buf_wp_ff <= {BUF_AW{1'b0}};
      buf_cnt_ff <= {(BUF_AW+1){1'b0}};
      locked_ff <= 1'b0;
   end
   else if (buf_clr)
   begin
      buf_wp_ff <= {BUF_AW{1'b0}}; // R10
      buf_cnt_ff <= {(BUF_AW+1){1'b0}};
      locked_ff <= 1'b0;
   end
   else
   begin
      if (buf_wr && !buf_full)
      begin
         buf_wp_ff <= buf_wp_ff + {{(BUF_AW-1){1'b0}}, 1'b1};
         buf_cnt_ff <= buf_cnt_ff + {{BUF_AW{1'b0}}, 1'b1};
      end
      if (cmd_wr && !busy && cmd == `CMD_STORE)
         locked_ff <= 1'b1; // R9
   end
end

// ------------------------------------------------------------
// Error queue; a full queue drops the newest entry
// ------------------------------------------------------------
wire errq_full = (errq_cnt_ff == ERRQ_DEPTH[ERRQ_AW:0]);
wire errq_wr = err_push & !errq_full;
always @(posedge pclk)
begin
   if (errq_wr)
      errq_mem[errq_wp_ff] <= err_code; // R24
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      errq_wp_ff <= {ERRQ_AW{1'b0}};
      errq_rp_ff <= {ERRQ_AW{1'b0}};
      errq_cnt_ff <= {(ERRQ_AW+1){1'b0}};
   end
   else
   begin
      if (errq_wr)
         errq_wp_ff <= errq_wp_ff + {{(ERRQ_AW-1){1'b0}}, 1'b1};
      if (errq_pop)
         errq_rp_ff <= errq_rp_ff + {{(ERRQ_AW-1){1'b0}}, 1'b1}; // R24
      if (errq_wr && !errq_pop)
         errq_cnt_ff <= errq_cnt_ff + {{ERRQ_AW{1'b0}}, 1'b1};
      else if (errq_pop && !errq_wr)
         errq_cnt_ff <= errq_cnt_ff - {{ERRQ_AW{1'b0}}, 1'b1};
   end
end

// ------------------------------------------------------------
// Read data mux
// ------------------------------------------------------------
wire errq_empty = (errq_cnt_ff == {(ERRQ_AW+1){1'b0}});
always @*
begin
   prdata = 32'h00000000;
   case (paddr)
      `OFS_ARGS:
         prdata = {16'h0000, samp_cnt_ff};
      `OFS_CTRL:
         prdata = {31'h00000000, cont_ff};
      `OFS_STATUS:
         prdata = {13'h0000, errq_cnt_ff[3:0], 3'h0, buf_cnt_ff, fresh_ff, locked_ff,
            armed_ff, busy, state_ff};
      `OFS_ERRQ:
         prdata = errq_empty ? 32'h00000000 : {16'h0001, errq_mem[errq_rp_ff]};
      `OFS_FMT:
         prdata = {19'h0, fmt_swap_ff, 2'h0, fmt_elem_ff, 2'h0, fmt_data_ff};
      `OFS_READING:
         prdata = latest_ff; // R23
      default:
         prdata = 32'h00000000;
   endcase
end

endmodule // measurement_query_sequencer

// File: rtl/query_seq_map.vh
/*
 Register offsets, field positions, reset values, error codes and command encodings for
 the measurement query sequencer. Assumes inclusion by bare name from the rtl folder.
*/
`ifndef QUERY_SEQ_MAP_VH
`define QUERY_SEQ_MAP_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CMD 12'h000
`define OFS_ARGS 12'h004
`define OFS_CTRL 12'h008
`define OFS_STATUS 12'h00C
`define OFS_ERRQ 12'h010
`define OFS_FMT 12'h014
`define OFS_READING 12'h018
`define OFS_BUFCLR 12'h01C
// ------------------------------------------------------------
// Command codes written to the command register
// ------------------------------------------------------------
`define CMD_READ 4'h1
`define CMD_MEAS 4'h2
`define CMD_INIT 4'h3
`define CMD_ABORT 4'h4
`define CMD_FETCH 4'h5
`define CMD_RST 4'h6
`define CMD_PRESET 4'h7
`define CMD_STORE 4'h8
// ------------------------------------------------------------
// Argument register fields
// ------------------------------------------------------------
`define ARG_FUNC_LSB 0
`define ARG_FUNCV_BIT 4
`define ARG_RANGE_LSB 8
`define ARG_RES_LSB 12
`define ARG_CHV_BIT 16
`define ARG_CH_LSB 20
// ------------------------------------------------------------
// Format register fields and reset values
// ------------------------------------------------------------
`define FMT_DATA_LSB 0
`define FMT_ELEM_LSB 4
`define FMT_SWAP_BIT 12
`define FMT_ASCII 2'h0
`define FMT_SREAL 2'h1
`define FMT_DREAL 2'h2
`define ELEM_RESET 6'h07
// ------------------------------------------------------------
// Error codes (two's complement, 16 bits) and digit limits
// ------------------------------------------------------------
`define ERR_INIT_IGN 16'hFF2B
`define ERR_SETTINGS 16'hFF23
`define ERR_MEMORY 16'hFF1F
`define DIG_MIN 4'h3
`define DIG_MAX 4'h7
`endif

// File: test/meas_engine_model.sv
/* Measurement engine model: answers each trigger start with a burst of readings.
 Assumes the bench sets samples and gap before the start. */
module meas_engine_model (
   input wire pclk,
   input wire presetn,
   input wire trig_start,
   input wire [15:0] samples,
   input wire [2:0] gap,
   output logic meas_done,
   output logic [31:0] meas_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] val;
   int left;
   int tmr;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         meas_done <= 1'b0;
         meas_data <= 32'h0;
         val <= 32'h0;
         left <= 0;
         tmr <= 0;
      end
      else
      begin
         meas_done <= 1'b0;
         // Data only valid with the strobe; between strobes it toggles each cycle between the last reading and its inverse
         meas_data <= ~meas_data;
         if (trig_start)
         begin
            left <= samples;
            tmr <= gap;
         end
         else if (left > 0 && tmr == 0)
         begin
            meas_done <= 1'b1;
            meas_data <= val + 32'h101;
            val <= val + 32'h101;
            left <= left - 1;
            tmr <= gap;
         end
         else if (left > 0)
            tmr <= tmr - 1;
      end
endmodule // meas_engine_model

// File: test/measurement_query_sequencer_chk.sv
/* Checker: port relations of the query sequencer.
 Assumes a bind from the bench top; presetn is low-active. */
module measurement_query_sequencer_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire meas_done,
   input wire [31:0] meas_data,
   input wire trig_start,
   input wire trig_idle,
   input wire func_defaults,
   input wire [3:0] digits
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   logic [31:0] last_ff;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         last_ff <= 32'h0;
      else if (meas_done)
         last_ff <= meas_data;
   property p_ready;
      acc |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
   property p_unmapped;
      acc && paddr >= 12'h020 |-> pslverr && (pwrite || prdata == 32'h0);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_mapped;
      acc && paddr < 12'h020 |-> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   property p_digits;
      digits >= 4'h3 && digits <= 4'h7;
   endproperty
   a_digits: assert property (p_digits) else $error("digits out of range");
   property p_arm;
      trig_start |=> !trig_idle;
   endproperty
   a_arm: assert property (p_arm) else $error("start left model idle");
   property p_dflt;
      func_defaults |=> !func_defaults;
   endproperty
   a_dflt: assert property (p_dflt) else $error("defaults not a pulse");
   property p_cfg_order;
      func_defaults |-> !trig_start ##1 !trig_start;
   endproperty
   a_cfg_order: assert property (p_cfg_order) else $error("start too soon");
   property p_latest;
      acc && !pwrite && paddr == 12'h018 |-> prdata == last_ff;
   endproperty
   a_latest: assert property (p_latest) else $error("reading not latest");
   c_start: cover property (trig_start);
   c_cfg: cover property (func_defaults);
   c_err: cover property (acc && pslverr);
endmodule // measurement_query_sequencer_chk

// File: test/measurement_query_sequencer_tb.sv
/* Bench top: APB master, engine model, queued read checks.
 Assumes the rtl header is on the include path. */
`include "query_seq_map.vh"
module measurement_query_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, sw;
   logic [11:0] paddr;
   logic [31:0] pwdata, q;
   logic [15:0] samples;
   logic [2:0] gap;
   logic [3:0] rs, rg, dexp;
   logic [7:0] ch;
   logic [5:0] el;
   logic [1:0] dt;
   logic close_seen;
   logic [63:0] expq[$];
   logic [63:0] e;
   int failures, compares, i;
   wire pready, pslverr, meas_done, trig_start, trig_idle, func_defaults, chan_close;
   wire [31:0] prdata, meas_data;
   wire [3:0] func_sel, range_sel, digits;
   wire [7:0] chan_num;
   measurement_query_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .meas_done, .meas_data, .trig_start, .trig_idle,
      .func_defaults, .func_sel, .range_sel, .digits, .chan_close, .chan_num);
   meas_engine_model u_eng (.pclk, .presetn, .trig_start, .samples, .gap, .meas_done,
      .meas_data);
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic report_and_stop();
      if (failures == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic give_up();
      failures++;
      report_and_stop();
   endtask
   task automatic cmp_rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x)
      begin
         failures++;
         $display("unexpected read %h expected %h seen %h", a, x, g);
      end
   endtask
   task automatic pin(input string n, input logic [7:0] x, input logic [7:0] g);
      compares++;
      if (g !== x)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask
   // ------
   // APB master: request held until pready is seen
   // ------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [31:0] m);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         expq.push_back({m, d & m});
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         give_up();
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d);
      apb(1'b0, a, d, 32'hFFFFFFFF);
   endtask
   task automatic cmd(input logic [3:0] c);
      apb(1'b1, `OFS_CMD, {28'h0, c}, 32'h0);
   endtask
   // Commands written while busy are dropped, so every sequence is drained first
   task automatic wait_done();
      int n;
      n = 0;
      do
      begin
         apb(1'b0, `OFS_STATUS, 32'h0, 32'h0);
         n++;
      end while (q[3] !== 1'b0 && n < 100);
      if (n >= 100)
         give_up();
   endtask
   always @(posedge pclk)
      if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0)
      begin
         e = expq.pop_front();
         if (e[63:32] != 32'h0)
            cmp_rd(paddr, e[31:0], prdata & e[63:32]);
      end
   // Channel opens again after the fetch, so its state is caught at the trigger start
   always @(posedge pclk)
      if (trig_start === 1'b1)
         close_seen <= chan_close;
   initial
   begin
      repeat (20000) @(posedge pclk);
      give_up();
   end
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      samples = 16'h1;
      gap = 3'h2;
      presetn = 1'b0;
      failures = 0;
      compares = 0;
      void'($urandom(87746));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      pin("trig_idle", 8'h01, {7'h0, trig_idle});
      rd(`OFS_FMT, 32'h00000070);
      rd(12'h020, 32'h0);
      wr(`OFS_ARGS, 32'h1);
      cmd(`CMD_READ);
      wait_done();
      rd(`OFS_READING, 32'h00000101);
      rd(`OFS_ERRQ, 32'h0);
      cmd(`CMD_INIT);
      @(posedge pclk);
      pin("trig_idle", 8'h00, {7'h0, trig_idle});
      wait_done();
      cmd(`CMD_ABORT);
      @(posedge pclk);
      pin("trig_idle", 8'h01, {7'h0, trig_idle});
      wr(`OFS_CTRL, 32'h1);
      cmd(`CMD_ABORT);
      @(posedge pclk);
      pin("trig_idle", 8'h00, {7'h0, trig_idle});
      wait_done();
      cmd(`CMD_INIT);
      cmd(`CMD_RST);
      rd(`OFS_CTRL, 32'h0);
      wait_done();
      wr(`OFS_ARGS, 32'h3);
      cmd(`CMD_STORE);
      cmd(`CMD_READ);
      wr(`OFS_CTRL, 32'h1);
      cmd(`CMD_READ);
      cmd(`CMD_RST);
      rd(`OFS_ERRQ, {16'h0001, `ERR_INIT_IGN});
      rd(`OFS_ERRQ, {16'h0001, `ERR_MEMORY});
      rd(`OFS_ERRQ, {16'h0001, `ERR_INIT_IGN});
      rd(`OFS_ERRQ, 32'h0);
      cmd(`CMD_PRESET);
      rd(`OFS_FMT, 32'h00001070);
      apb(1'b0, `OFS_STATUS, 32'h20, 32'h20);
      cmd(`CMD_RST);
      rd(`OFS_FMT, 32'h00000070);
      wr(`OFS_BUFCLR, 32'h0);
      samples <= 16'h3;
      cmd(`CMD_READ);
      wait_done();
      apb(1'b0, `OFS_STATUS, 32'h180, 32'hFA0);
      for (i = 0; i < 4; i++)
      begin
         dt = 2'(i);
         el = 6'($urandom);
         sw = 1'($urandom);
         wr(`OFS_FMT, {19'h0, sw, 2'h0, el, 2'h0, dt});
         rd(`OFS_FMT, {19'h0, sw, 2'h0, el, 2'h0, (dt == 2'h3) ? 2'h0 : dt});
      end
      samples <= 16'h1;
      wr(`OFS_ARGS, 32'h1);
      for (i = 0; i < 8; i++)
      begin
         rs = (i == 0) ? 4'h3 : 4'($urandom_range(7, 0));
         rg = (i == 0) ? 4'h2 : 4'($urandom_range(7, 0));
         ch = 8'($urandom);
         gap <= 3'($urandom_range(4, 1));
         wr(`OFS_CMD, {4'h0, ch, 3'h0, 1'b1, rs, rg, 3'h0, 1'(i != 0), `CMD_MEAS});
         wait_done();
         if (rs + rg > 7)
            rd(`OFS_ERRQ, {16'h0001, `ERR_SETTINGS});
         else
         begin
            dexp = (rs + rg < 3) ? 4'h3 : rs + rg;
            pin("func_sel", (i == 0) ? 8'h00 : 8'h02, {4'h0, func_sel});
            pin("range_sel", {4'h0, rg}, {4'h0, range_sel});
            pin("chan_num", ch, chan_num);
            pin("chan_close", 8'h01, {7'h0, close_seen});
         end
         pin("digits", {4'h0, dexp}, {4'h0, digits});
      end
      wr(`OFS_CTRL, 32'h1);
      wr(`OFS_CMD, {4'h0, 8'h05, 3'h0, 1'b1, 4'h2, 4'h2, 3'h0, 1'b1, `CMD_MEAS});
      wait_done();
      rd(`OFS_CTRL, 32'h0);
      rd(`OFS_ERRQ, 32'h0);
      report_and_stop();
   end
endmodule // measurement_query_sequencer_tb
bind measurement_query_sequencer measurement_query_sequencer_chk u_chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .meas_done, .meas_data,
   .trig_start, .trig_idle, .func_defaults, .digits);
